// [hw/junction_comp.v]
`timescale 1ns/100ps
`include "thermo_fault_map.vh"

// Module-wide cold-junction correction applied to every channel
module junction_comp (
    input wire ref_clk_i,
    input wire nrst_i,
    input wire update_i,
    input wire junction_disable_i,
    input wire signed [`TEMP_W-1:0] junction_offset_i,
    input wire signed [`TEMP_W-1:0] junction_temp_i,
    output reg signed [`TEMP_W-1:0] comp_value_o
);

    wire signed [`TEMP_W:0] sum;

    // Offset added at one extra bit, then saturated to the word width
    assign sum = {junction_temp_i[`TEMP_W-1], junction_temp_i}
        + {junction_offset_i[`TEMP_W-1], junction_offset_i};

    // Latched once per input update so all channels see the same value
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            comp_value_o <= `COMP_RESET;
        end
        else if (update_i)
        begin
            if (junction_disable_i)
            begin
                comp_value_o <= `COMP_RESET;
            end
            else if (sum[`TEMP_W] != sum[`TEMP_W-1])
            begin
                comp_value_o <= sum[`TEMP_W] ? `COMP_SAT_MIN : `COMP_SAT_MAX;
            end
            else
            begin
                comp_value_o <= sum[`TEMP_W-1:0];
            end
        end
    end

endmodule // junction_comp

// [hw/thermo_fault_report.v]
// How it works
// - Disable drops junction compensation on all channels
// - One offset corrects the junction value module-wide
// - Six channels, each with own status word
// - Words sent with every channel data transfer
// - Bits 15,14 set when any channel fault
// - Bit 12 while calibrating; fault word forced
// - Bit 11 is OR of calibration faults
// - Bit 9 when junction below zero, thermocouple variant only
// - Bit 8 when junction above 86 C, thermocouple variant only
// - Bits 13 and 10 read zero
// - Channel fault bit n belongs to channel n
// - Status word bit layout, fault to high-high
// - Alarm bits never reach higher words
// - Range bits set channel's fault bit
// - Calibrating makes fault word 003f unless owner link lost
// - Lost owner link makes fault word ffff
`timescale 1ns/100ps
`include "thermo_fault_map.vh"

module thermo_fault_report (
    input wire ref_clk_i,
    input wire nrst_i,
    input wire update_i,
    input wire thermocouple_variant_i,
    input wire junction_disable_i,
    input wire remote_junction_i,
    input wire signed [`TEMP_W-1:0] junction_offset_i,
    input wire signed [`TEMP_W-1:0] local_junction_temp_i,
    input wire signed [`TEMP_W-1:0] remote_junction_temp_i,
    input wire [`NUM_CHANNELS-1:0] cal_error_i,
    input wire [`NUM_CHANNELS-1:0] below_range_i,
    input wire [`NUM_CHANNELS-1:0] above_range_i,
    input wire [`NUM_CHANNELS-1:0] rate_alarm_i,
    input wire [`NUM_CHANNELS-1:0] low_alarm_i,
    input wire [`NUM_CHANNELS-1:0] high_alarm_i,
    input wire [`NUM_CHANNELS-1:0] low_low_alarm_i,
    input wire [`NUM_CHANNELS-1:0] high_high_alarm_i,
    input wire [`NUM_CHANNELS-1:0] calibrating_i,
    input wire comm_fail_i,
    input wire [`NUM_CHANNELS*`TEMP_W-1:0] channel_data_i,
    output reg [`WORD_W-1:0] module_fault_summary_o,
    output reg [`WORD_W-1:0] channel_fault_summary_o,
    output reg [`NUM_CHANNELS*`STATUS_W-1:0] per_channel_status_o,
    output reg [`NUM_CHANNELS*`TEMP_W-1:0] channel_data_o,
    output reg signed [`TEMP_W-1:0] junction_comp_o,
    output reg transfer_valid_o
);

    // Fixed update pipeline: compute on update, send one cycle later
    localparam ST_IDLE = 2'b00;
    localparam ST_EVAL = 2'b01;
    localparam ST_SEND = 2'b10;

    // Sequencer state
    reg [1:0] state_q;
    reg [1:0] state_d;

    // Next values of the outgoing words
    wire [`NUM_CHANNELS*`STATUS_W-1:0] status_d;
    reg [`WORD_W-1:0] chan_fault_d;
    reg [`WORD_W-1:0] mod_fault_d;

    // Junction path and channel reductions
    reg signed [`TEMP_W-1:0] junction_sel;
    wire signed [`TEMP_W-1:0] comp_value;
    wire any_cal;
    wire any_cal_fault;
    wire [`NUM_CHANNELS-1:0] range_fault;

    // Remote sensor chosen when configured for an interface module
    always @*
    begin
        if (remote_junction_i)
        begin
            junction_sel = remote_junction_temp_i;
        end
        else
        begin
            junction_sel = local_junction_temp_i;
        end
    end

    // Shared compensation value for all six channels
    junction_comp u_comp (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .update_i(update_i),
        .junction_disable_i(junction_disable_i),
        .junction_offset_i(junction_offset_i),
        .junction_temp_i(junction_sel),
        .comp_value_o(comp_value)
    );

    // Pack one status byte per channel
    function [`STATUS_W-1:0] pack_status;
        input cal;
        input below;
        input above;
        input rate;
        input lo;
        input hi;
        input lolo;
        input hihi;
        begin
            pack_status = `ST_RESET;
            pack_status[`ST_CAL_FAULT] = cal;
            pack_status[`ST_BELOW_RANGE] = below;
            pack_status[`ST_ABOVE_RANGE] = above;
            pack_status[`ST_RATE_ALARM] = rate;
            pack_status[`ST_LOW_ALARM] = lo;
            pack_status[`ST_HIGH_ALARM] = hi;
            pack_status[`ST_LOW_LOW_ALARM] = lolo;
            pack_status[`ST_HIGH_HIGH_ALARM] = hihi;
        end
    endfunction

    // True when any of the six channel bits is set
    function any_channel;
        input [`NUM_CHANNELS-1:0] bits;
        begin
            any_channel = |bits;
        end
    endfunction

    // Group flag: any bit of the channel fault word
    function group_flag;
        input [`WORD_W-1:0] word;
        begin
            group_flag = |word;
        end
    endfunction

    // Per-channel status words and range faults
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1)
        begin : g_chan
            // Status byte of this channel
            assign status_d[ch*`STATUS_W +: `STATUS_W] = pack_status(
                cal_error_i[ch], below_range_i[ch], above_range_i[ch],
                rate_alarm_i[ch], low_alarm_i[ch], high_alarm_i[ch],
                low_low_alarm_i[ch], high_high_alarm_i[ch]);
            // Only range bits feed the fault word; alarms stay local
            assign range_fault[ch] = below_range_i[ch] | above_range_i[ch];
        end
    endgenerate

    assign any_cal = any_channel(calibrating_i);
    assign any_cal_fault = any_channel(cal_error_i);

    // Channel fault word with forced patterns
    always @*
    begin
        chan_fault_d = `CF_RESET;
        if (comm_fail_i)
        begin
            chan_fault_d = `CF_COMM_FAIL;
        end
        else if (any_cal)
        begin
            chan_fault_d = `CF_CALIBRATING;
        end
        else
        begin
            chan_fault_d[`NUM_CHANNELS-1:0] = range_fault;
        end
    end

    // Module fault summary word
    always @*
    begin
        mod_fault_d = `MS_RESET;
        // Group flags follow the channel fault word
        mod_fault_d[`MS_ANALOG_GROUP] = group_flag(chan_fault_d);
        mod_fault_d[`MS_INPUT_GROUP] = group_flag(chan_fault_d);
        // Unused positions stay clear
        mod_fault_d[`MS_UNUSED_HI] = 1'b0;
        mod_fault_d[`MS_UNUSED_LO] = 1'b0;
        // Calibration state and errors
        mod_fault_d[`MS_CALIBRATING] = any_cal;
        mod_fault_d[`MS_CAL_FAULT] = any_cal_fault;
        // Junction limits on the raw selected sensor, thermocouple only
        mod_fault_d[`MS_JUNCTION_LOW] = thermocouple_variant_i
            && (junction_sel < `JUNCTION_LOW_LIMIT);
        mod_fault_d[`MS_JUNCTION_HIGH] = thermocouple_variant_i
            && (junction_sel > `JUNCTION_HIGH_LIMIT);
    end

    // Sequencer next state
    always @*
    begin
        case (state_q)
            ST_IDLE:
            begin
                state_d = update_i ? ST_EVAL : ST_IDLE;
            end
            ST_EVAL:
            begin
                // Back-to-back updates keep the strobe going
                state_d = update_i ? ST_EVAL : ST_SEND;
            end
            ST_SEND:
            begin
                state_d = update_i ? ST_EVAL : ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Module summary word, refreshed on each update
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            module_fault_summary_o <= `MS_RESET;
        end
        else if (update_i)
        begin
            module_fault_summary_o <= mod_fault_d;
        end
    end

    // Channel fault word, refreshed on each update
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            channel_fault_summary_o <= `CF_RESET;
        end
        else if (update_i)
        begin
            channel_fault_summary_o <= chan_fault_d;
        end
    end

    // Status bytes of all six channels
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            per_channel_status_o <= {`NUM_CHANNELS{`ST_RESET}};
        end
        else if (update_i)
        begin
            per_channel_status_o <= status_d;
        end
    end

    // Channel data is taken with the words it travels with
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            channel_data_o <= `CH_DATA_RESET;
        end
        else if (update_i)
        begin
            channel_data_o <= channel_data_i;
        end
    end

    // Compensation published once the update is evaluated
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            junction_comp_o <= `COMP_RESET;
        end
        else if (state_q == ST_EVAL)
        begin
            junction_comp_o <= comp_value;
        end
    end

    // Transfer strobe, one cycle per evaluated update
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            transfer_valid_o <= 1'b0;
        end
        else
        begin
            transfer_valid_o <= (state_q == ST_EVAL);
        end
    end

endmodule // thermo_fault_report

// [shared/thermo_fault_map.vh]
`ifndef THERMO_FAULT_MAP_VH
`define THERMO_FAULT_MAP_VH
// Channel count and word widths
`define NUM_CHANNELS 6
`define CH_IDX_W 3
`define STATUS_W 8
`define WORD_W 16
`define TEMP_W 16
// Per-channel status word bit positions
`define ST_CAL_FAULT 7
`define ST_BELOW_RANGE 6
`define ST_ABOVE_RANGE 5
`define ST_RATE_ALARM 4
`define ST_LOW_ALARM 3
`define ST_HIGH_ALARM 2
`define ST_LOW_LOW_ALARM 1
`define ST_HIGH_HIGH_ALARM 0
// Module summary bit positions
`define MS_ANALOG_GROUP 15
`define MS_INPUT_GROUP 14
`define MS_UNUSED_HI 13
`define MS_CALIBRATING 12
`define MS_CAL_FAULT 11
`define MS_UNUSED_LO 10
`define MS_JUNCTION_LOW 9
`define MS_JUNCTION_HIGH 8
// Fixed channel fault word patterns and reset values of the words
`define CF_CALIBRATING 16'h003f
`define CF_COMM_FAIL 16'hffff
`define CF_RESET 16'h0000
`define MS_RESET 16'h0000
`define ST_RESET 8'h00
`define CH_DATA_RESET 96'h0
// Compensation reset value and saturation limits
`define COMP_RESET 16'sh0000
`define COMP_SAT_MIN 16'sh8000
`define COMP_SAT_MAX 16'sh7fff
// Junction temperature limits, signed tenths of a degree Celsius
`define JUNCTION_LOW_LIMIT 16'sh0000
`define JUNCTION_HIGH_LIMIT 16'sh035c
`endif

// [sim/owner_ctrl_model.sv]
`timescale 1ns/100ps
// Owner controller side: latches each multicast set of words
module owner_ctrl_model (
    input wire ref_clk_i,
    input wire nrst_i,
    input wire transfer_valid_i,
    input wire [15:0] module_fault_i,
    input wire [15:0] channel_fault_i,
    output reg [15:0] seen_mod_o,
    output reg [15:0] seen_ch_o
);
    // Take the words only while a transfer is announced
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            seen_mod_o <= 16'h0000;
            seen_ch_o <= 16'h0000;
        end
        else if (transfer_valid_i)
        begin
            seen_mod_o <= module_fault_i;
            seen_ch_o <= channel_fault_i;
        end
    end
endmodule // owner_ctrl_model

// [sim/tb_thermo_fault_report.sv]
`timescale 1ns/100ps
module tb_thermo_fault_report;
    reg ref_clk_i, nrst_i, update_i, thermocouple_variant_i, junction_disable_i;
    reg remote_junction_i, comm_fail_i;
    reg [15:0] junction_offset_i, local_junction_temp_i, remote_junction_temp_i;
    reg [5:0] cal_error_i, below_range_i, above_range_i, calibrating_i;
    reg [29:0] alarm;
    reg [95:0] chan_data;
    wire [15:0] module_fault_summary_o, channel_fault_summary_o, seen_m, seen_c;
    wire [47:0] per_channel_status_o;
    wire [95:0] channel_data_o;
    wire signed [15:0] junction_comp_o;
    wire transfer_valid_o;
    integer errors, n_checks, i;
    // Alarm groups: rate, low, high, low-low, high-high, six bits each
    thermo_fault_report u_dut (.ref_clk_i, .nrst_i, .update_i, .thermocouple_variant_i,
        .junction_disable_i, .remote_junction_i, .junction_offset_i,
        .local_junction_temp_i, .remote_junction_temp_i, .cal_error_i, .below_range_i,
        .above_range_i, .rate_alarm_i(alarm[29:24]), .low_alarm_i(alarm[23:18]),
        .high_alarm_i(alarm[17:12]), .low_low_alarm_i(alarm[11:6]),
        .high_high_alarm_i(alarm[5:0]), .calibrating_i, .comm_fail_i,
        .channel_data_i(chan_data), .module_fault_summary_o,
        .channel_fault_summary_o, .per_channel_status_o, .channel_data_o,
        .junction_comp_o, .transfer_valid_o);
    owner_ctrl_model u_owner (.ref_clk_i, .nrst_i, .transfer_valid_i(transfer_valid_o),
        .module_fault_i(module_fault_summary_o), .channel_fault_i(channel_fault_summary_o),
        .seen_mod_o(seen_m), .seen_ch_o(seen_c));
    always #4 ref_clk_i = ~ref_clk_i;
    task finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [95:0] e, input logic [95:0] g);
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            errors = errors + 1;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // One sample set, then the words and the owner's copy
    task run(input [15:0] em, input [15:0] ec);
        @(negedge ref_clk_i) update_i = 1'b1;
        @(negedge ref_clk_i) update_i = 1'b0;
        i = 0;
        while (transfer_valid_o !== 1'b1 && i < 8)
        begin
            @(negedge ref_clk_i);
            i = i + 1;
        end
        if (transfer_valid_o !== 1'b1)
        begin
            errors = errors + 1;
            finish_test;
        end
        chk("module", em, module_fault_summary_o);
        chk("channel", ec, channel_fault_summary_o);
        @(negedge ref_clk_i);
        chk("pulse", 0, transfer_valid_o);
        chk("owner_mod", em, seen_m);
        chk("owner_ch", ec, seen_c);
    endtask
    task t_range;
        below_range_i = 6'h01;
        above_range_i = 6'h20;
        alarm = {6'h05, 6'h20, 6'h20, 6'h01, 6'h20};
        chan_data = 96'h5555_4444_3333_2222_1111_0a0b;
        run(16'hc000, 16'h0021);
        chk("status", 48'h2d00_0010_0052, per_channel_status_o);
        chk("data", 96'h5555_4444_3333_2222_1111_0a0b, channel_data_o);
        $display("t_range done");
    endtask
    // Reset in mid-run clears words that were set
    task t_reset;
        @(negedge ref_clk_i) nrst_i = 1'b0;
        @(negedge ref_clk_i);
        chk("mod_rst2", 0, module_fault_summary_o);
        chk("ch_rst2", 0, channel_fault_summary_o);
        chk("st_rst2", 0, per_channel_status_o);
        chk("data_rst2", 0, channel_data_o);
        chk("owner_rst2", 0, seen_c);
        nrst_i = 1'b1;
        $display("t_reset done");
    endtask
    task t_cal;
        below_range_i = 6'h00;
        above_range_i = 6'h00;
        alarm = 30'h0;
        calibrating_i = 6'h04;
        cal_error_i = 6'h02;
        chan_data = 96'h0123_4567_89ab_cdef_fedc_ba98;
        run(16'hd800, 16'h003f);
        chk("st1", 8'h80, per_channel_status_o[15:8]);
        chk("data2", 96'h0123_4567_89ab_cdef_fedc_ba98, channel_data_o);
        comm_fail_i = 1'b1;
        cal_error_i = 6'h00;
        run(16'hd000, 16'hffff);
        comm_fail_i = 1'b0;
        calibrating_i = 6'h00;
        run(16'h0000, 16'h0000);
        $display("t_cal done");
    endtask
    task t_junc;
        thermocouple_variant_i = 1'b1;
        junction_offset_i = 16'h000c;
        local_junction_temp_i = 16'hffff;
        run(16'h0200, 16'h0000);
        chk("comp", 16'h000b, junction_comp_o);
        remote_junction_i = 1'b1;
        remote_junction_temp_i = 16'h035d;
        run(16'h0100, 16'h0000);
        chk("comp", 16'h0369, junction_comp_o);
        junction_offset_i = 16'h7000;
        remote_junction_temp_i = 16'h7000;
        run(16'h0100, 16'h0000);
        chk("comp_sat", 16'h7fff, junction_comp_o);
        remote_junction_temp_i = 16'h035c;
        junction_disable_i = 1'b1;
        run(16'h0000, 16'h0000);
        chk("comp", 16'h0000, junction_comp_o);
        $display("t_junc done");
    endtask
    initial
    begin
        {ref_clk_i, nrst_i, update_i, thermocouple_variant_i, junction_disable_i} = 5'h00;
        {remote_junction_i, comm_fail_i, alarm, calibrating_i} = 38'h0;
        chan_data = 96'h0;
        {cal_error_i, below_range_i, above_range_i} = 18'h00000;
        {junction_offset_i, local_junction_temp_i, remote_junction_temp_i} = 48'h0;
        errors = 0;
        n_checks = 0;
        repeat (2) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        chk("mod_rst", 0, module_fault_summary_o);
        chk("st_rst", 0, per_channel_status_o);
        t_range;
        t_reset;
        t_cal;
        t_junc;
        finish_test;
    end
endmodule // tb_thermo_fault_report
bind thermo_fault_report thermo_fault_report_chk u_chk (.ref_clk_i, .nrst_i, .update_i,
    .junction_disable_i, .cal_error_i, .below_range_i, .above_range_i, .rate_alarm_i,
    .calibrating_i, .comm_fail_i, .module_fault_summary_o, .channel_fault_summary_o,
    .per_channel_status_o, .junction_comp_o, .transfer_valid_o);

// [sim/thermo_fault_report_chk.sv]
`timescale 1ns/100ps
// Ties the fault words to the sampled causes
module thermo_fault_report_chk (
    input wire ref_clk_i,
    input wire nrst_i,
    input wire update_i,
    input wire junction_disable_i,
    input wire [5:0] cal_error_i,
    input wire [5:0] below_range_i,
    input wire [5:0] above_range_i,
    input wire [5:0] rate_alarm_i,
    input wire [5:0] calibrating_i,
    input wire comm_fail_i,
    input wire [15:0] module_fault_summary_o,
    input wire [15:0] channel_fault_summary_o,
    input wire [47:0] per_channel_status_o,
    input wire signed [15:0] junction_comp_o,
    input wire transfer_valid_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    wire [15:0] ms = module_fault_summary_o;
    wire [15:0] cf = channel_fault_summary_o;
    group_bits_a: assert property (ms[15:14] == {2{|cf}})
        else $error("group bits wrong");
    unused_zero_a: assert property (!ms[13] && !ms[10])
        else $error("unused bits set");
    calib_bit_a: assert property (update_i |=> ms[12] == $past(|calibrating_i))
        else $error("calibrating bit wrong");
    calerr_bit_a: assert property (update_i |=> ms[11] == $past(|cal_error_i))
        else $error("cal fault bit wrong");
    comm_word_a: assert property (update_i && comm_fail_i |=> cf == 16'hffff)
        else $error("comm word wrong");
    cal_word_a: assert property (update_i && !comm_fail_i && |calibrating_i
        |=> cf == 16'h003f)
        else $error("cal word wrong");
    range_word_a: assert property (update_i && !comm_fail_i && calibrating_i == 6'h00
        |=> cf == {10'h000, $past(below_range_i | above_range_i)})
        else $error("range word wrong");
    status_rate_a: assert property (update_i
        |=> per_channel_status_o[4] == $past(rate_alarm_i[0]))
        else $error("rate bit wrong");
    send_pulse_a: assert property (update_i |-> ##2 transfer_valid_o)
        else $error("no transfer");
    comp_off_a: assert property (update_i && junction_disable_i
        |-> ##2 junction_comp_o == 16'sh0000)
        else $error("comp not off");
    hold_word_a: assert property (!update_i |=> $stable(cf))
        else $error("word moved");
endmodule // thermo_fault_report_chk
